// ===== inc/plh_pkg.sv
// package: register map, field layout, reset values and types of the lock-detect/holdover block
package plh_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, word aligned)
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_LOCK_CNT  = 5'h04;
  localparam logic [4:0] ADDR_WINDOW    = 5'h08;
  localparam logic [4:0] ADDR_MANUAL_DAC_CODE   = 5'h0c;
  localparam logic [4:0] ADDR_STATUS    = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STAT  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h18;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int          CNT_W          = 16;
  localparam int          PHASE_W        = 12;
  localparam int          DAC_W          = 10;
  localparam int          EVT_W          = 4;
  localparam logic [15:0] LOCK_COUNT_RST = 16'h2710;
  localparam logic [11:0] WINDOW_RST     = 12'h010;
  localparam logic [9:0]  DAC_MID_RST    = 10'h200;
  localparam logic [1:0]  HOLD_MODE_ON   = 2'h2;
  localparam logic [1:0]  HOLD_MODE_RST  = 2'h2;

  // phase-detector rate used to relate lock count to lock time
  localparam int PD_RATE_KHZ  = 3840;
  localparam int LOCK_TIME_US = (10000 * 1000) / PD_RATE_KHZ;

  // ----------------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------------
  localparam int CTRL_HOLD_MODE = 0;
  localparam int CTRL_TRACK_EN  = 2;
  localparam int CTRL_MAN_SEL   = 3;
  localparam int CTRL_HOLD_DIS  = 4;
  localparam int CTRL_OSC_67    = 5;
  localparam int CTRL_OSC_89    = 6;
  localparam logic [6:0] CTRL_RST = 7'h02;

  // interrupt event bit positions
  localparam int EVT_LOCK_GAIN = 0;
  localparam int EVT_LOCK_LOSS = 1;
  localparam int EVT_HOLD_IN   = 2;
  localparam int EVT_HOLD_OUT  = 3;

  typedef struct packed {
    logic       osc89;
    logic       osc67;
    logic       holdDis;
    logic       manSel;
    logic       trackEn;
    logic [1:0] holdMode;
  } plh_ctrl_t;

  typedef enum logic [0:0] {
    ST_LOCKING,
    ST_HOLDOVER
  } plh_state_t;

endpackage

// ===== core/plh_lock_holdover.sv
// lock detector, holdover control and Avalon-MM register file for the first loop
//
// Contract
// R1: lock flag rises only after the programmed lock count of consecutive comparisons is in window.
// R2: lock flag goes high once the phase difference stayed inside the window for the count.
// R3: lock flag drops as soon as a comparison falls outside the window.
// R4: with lock-loss holdover disable at 0, a falling lock flag enters holdover.
// R5: holdover exits when the reference is valid, and locking restarts from zero.
// R6: a holdover mode value of 2 enables holdover operation.
// R7: tracking enable at 0 stops the holdover DAC from following the tuning voltage.
// R8: manual DAC select at 1 takes the holdover voltage from the manual DAC code.
// R9: a manual DAC code of 512 is midscale, about half the supply.
// R10: output pairs six/seven and eight/nine each select the oscillator or the divider path.
// R11: software should program a lock count large enough that the lock flag does not chatter.
// R12: the comparison counter restarts from zero on any out-of-window comparison.
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module plh_lock_holdover #(
  parameter int PHASE_W = plh_pkg::PHASE_W,
  parameter int DAC_W   = plh_pkg::DAC_W
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Avalon-MM slave
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // interrupt
  output logic                     irq,
  // phase comparison from the loop phase detector, same clock
  input  wire logic                cmpValid,
  input  wire logic [PHASE_W-1:0]  phaseErr,
  // tuning voltage code seen by the oscillator, same clock
  input  wire logic [DAC_W-1:0]    tuneCode,
  // reference valid from the input monitor, asynchronous
  input  wire logic                refValid,
  // loop status and holdover drive
  output logic                     lockFlag,
  output logic                     holdover,
  output logic                     dacHold,
  output logic      [DAC_W-1:0]    dacCode,
  // output pair sources: 1 = oscillator, 0 = divider
  output logic                     oscSelPair67,
  output logic                     oscSelPair89
);
  import plh_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  plh_ctrl_t          ctrl_q;
  logic [CNT_W-1:0]   lockCount_q;
  logic [PHASE_W-1:0] window_q;
  logic [DAC_W-1:0]   manDac_q;
  logic [EVT_W-1:0]   irqStat_q;
  logic [EVT_W-1:0]   irqMask_q;
  logic               waitreq_q;
  logic [31:0]        rdata_q;
  logic               irq_q;

  logic               refMeta_q;
  logic               refSync_q;
  logic [CNT_W-1:0]   cmpCnt_q;
  logic               lock_q;
  plh_state_t         state_q;
  logic [DAC_W-1:0]   tracked_q;
  logic [DAC_W-1:0]   dac_q;
  logic               osc67_q;
  logic               osc89_q;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // one wait cycle per access: waitrequest drops for exactly one cycle
  wire busReq    = avs_read | avs_write;
  wire busAck    = busReq & ~waitreq_q;
  wire wrTake    = avs_write & ~waitreq_q;
  wire rdPrep    = avs_read & waitreq_q;
  wire selCtrl   = (avs_address == ADDR_CTRL);
  wire selCnt    = (avs_address == ADDR_LOCK_CNT);
  wire selWin    = (avs_address == ADDR_WINDOW);
  wire selDac    = (avs_address == ADDR_MANUAL_DAC_CODE);
  wire selStat   = (avs_address == ADDR_STATUS);
  wire selIrqS   = (avs_address == ADDR_IRQ_STAT);
  wire selIrqM   = (avs_address == ADDR_IRQ_MASK);
  wire irqRdClr  = avs_read & busAck & selIrqS;

  wire [31:0] statusWord = {{(28-DAC_W){1'b0}}, tracked_q, 1'b0, refSync_q,
                            (state_q == ST_HOLDOVER), lock_q};

  // unmapped addresses read as zero and ignore writes
  wire [31:0] rdMux =
    selCtrl ? {25'h0, ctrl_q} :
    selCnt  ? {16'h0, lockCount_q} :
    selWin  ? {{(32-PHASE_W){1'b0}}, window_q} :
    selDac  ? {{(32-DAC_W){1'b0}}, manDac_q} :
    selStat ? statusWord :
    selIrqS ? {28'h0, irqStat_q} :
    selIrqM ? {28'h0, irqMask_q} : 32'h0;

  // ----------------------------------------------------------------------
  // lock detector
  // ----------------------------------------------------------------------
  wire               errNeg   = phaseErr[PHASE_W-1];
  wire [PHASE_W-1:0] errAbs   = errNeg ? (~phaseErr + 1'b1) : phaseErr;
  wire               inWindow = (errAbs <= window_q);
  wire               cntDone  = (cmpCnt_q >= lockCount_q - 1'b1);
  wire               inHold   = (state_q == ST_HOLDOVER);
  wire               holdOn   = (ctrl_q.holdMode == HOLD_MODE_ON); // R6
  wire               lossDet  = lock_q & cmpValid & ~inWindow;
  wire               gainDet  = ~lock_q & cmpValid & inWindow & cntDone & ~inHold;
  wire               enterHo  = lossDet & ~ctrl_q.holdDis & holdOn; // R4
  wire               exitHo   = inHold & refSync_q; // R5

  wire [CNT_W-1:0] cntNext =
    (inHold | exitHo)       ? {CNT_W{1'b0}} : // R5
    ~cmpValid               ? cmpCnt_q :
    ~inWindow               ? {CNT_W{1'b0}} : // R12
    (cmpCnt_q == {CNT_W{1'b1}}) ? cmpCnt_q :
    cmpCnt_q + 1'b1;

  wire lockNext =
    inHold  ? 1'b0 :
    lossDet ? 1'b0 : // R3
    gainDet ? 1'b1 : // R1 R2
    lock_q;

  // ----------------------------------------------------------------------
  // holdover voltage
  // ----------------------------------------------------------------------
  // tracked value freezes while tracking is off or in holdover
  // also frozen on the entry cycle, so the held code cannot step one cycle later
  wire trackUpd = ctrl_q.trackEn & ~inHold & ~enterHo & cmpValid; // R7
  wire [DAC_W-1:0] holdVal = ctrl_q.manSel ? manDac_q : tracked_q; // R8 R9
  wire [DAC_W-1:0] dacNext = (inHold | enterHo) ? holdVal : tuneCode;

  wire [EVT_W-1:0] evt;
  assign evt[EVT_LOCK_GAIN] = gainDet;
  assign evt[EVT_LOCK_LOSS] = lossDet;
  assign evt[EVT_HOLD_IN]   = enterHo;
  assign evt[EVT_HOLD_OUT]  = exitHo;

  // set wins over a read clear in the same cycle; an event set in the read's wait cycle is cleared unread
  wire [EVT_W-1:0] irqNext = (irqRdClr ? {EVT_W{1'b0}} : irqStat_q) | evt;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0;
    end else begin
      waitreq_q <= ~(busReq & waitreq_q);
      if (rdPrep) begin
        rdata_q <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= CTRL_RST;
      lockCount_q <= LOCK_COUNT_RST;
      window_q    <= WINDOW_RST;
      manDac_q    <= DAC_MID_RST;
      irqMask_q   <= {EVT_W{1'b0}};
    end else if (wrTake) begin
      if (selCtrl) begin
        ctrl_q <= avs_writedata[6:0];
      end
      if (selCnt) begin
        lockCount_q <= avs_writedata[CNT_W-1:0]; // R11
      end
      if (selWin) begin
        window_q <= avs_writedata[PHASE_W-1:0];
      end
      if (selDac) begin
        manDac_q <= avs_writedata[DAC_W-1:0];
      end
      if (selIrqM) begin
        irqMask_q <= avs_writedata[EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_q <= {EVT_W{1'b0}};
      irq_q     <= 1'b0;
    end else begin
      irqStat_q <= irqNext;
      irq_q     <= |(irqNext & irqMask_q);
    end
  end

  // ----------------------------------------------------------------------
  // reference synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refMeta_q <= 1'b0;
      refSync_q <= 1'b0;
    end else begin
      refMeta_q <= refValid;
      refSync_q <= refMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // lock counter, lock flag and holdover state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpCnt_q <= {CNT_W{1'b0}};
      lock_q   <= 1'b0;
    end else begin
      cmpCnt_q <= cntNext;
      lock_q   <= lockNext;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_LOCKING;
    end else begin
      case (state_q)
        ST_LOCKING: begin
          if (enterHo) begin
            state_q <= ST_HOLDOVER; // R4
          end
        end
        ST_HOLDOVER: begin
          if (exitHo) begin
            state_q <= ST_LOCKING; // R5
          end
        end
        default: begin
          state_q <= ST_LOCKING;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // DAC value and output pair selectors
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tracked_q <= DAC_MID_RST;
      dac_q     <= DAC_MID_RST;
      osc67_q   <= 1'b0;
      osc89_q   <= 1'b0;
    end else begin
      if (trackUpd) begin
        tracked_q <= tuneCode; // R7
      end
      dac_q   <= dacNext; // R8
      osc67_q <= ctrl_q.osc67; // R10
      osc89_q <= ctrl_q.osc89; // R10
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // holdover is a flop of its own so the output does not hang off the enum
  logic holdOut_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdOut_q <= 1'b0;
    end else begin
      holdOut_q <= (state_q == ST_LOCKING) ? enterHo : ~exitHo;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign irq             = irq_q;
  assign lockFlag        = lock_q;
  assign holdover        = holdOut_q;
  assign dacHold         = holdOut_q;
  assign dacCode         = dac_q;
  assign oscSelPair67    = osc67_q;
  assign oscSelPair89    = osc89_q;

endmodule
`default_nettype wire

// ===== tb/plh_ref_model.sv
// partner model: phase comparisons, tuning code and reference-valid level
`timescale 1ns/1ns
`default_nettype none
module plh_ref_model (
  // clock
  input  wire logic   clk,
  // bench commands
  input  wire logic   inWindow,
  input  wire logic   refGood,
  // toward the block
  output logic        cmpValid,
  output logic [11:0] phaseErr,
  output logic [9:0]  tuneCode,
  output logic        refValid
);
  logic [1:0] div_q = 2'h0;
  // ------------------------------------------------------------
  // one comparison every fourth cycle
  // ------------------------------------------------------------
  initial begin
    cmpValid = 1'b0;
    phaseErr = 12'h000;
    tuneCode = 10'h200;
    refValid = 1'b0;
  end
  // error bus toggles between comparisons so stale values never look valid
  always @(posedge clk) begin
    div_q    <= div_q + 2'h1;
    cmpValid <= (div_q == 2'h3);
    phaseErr <= (div_q != 2'h3) ? ~phaseErr : (inWindow ? 12'hff0 : 12'h011);
    tuneCode <= (div_q == 2'h3) ? tuneCode + 10'h3 : tuneCode;
    refValid <= refGood;
  end
endmodule
`default_nettype wire

// ===== tb/plh_lock_holdover_checker.sv
// checker: port assertions of the lock-detect/holdover block
`timescale 1ns/1ns
`default_nettype none
module plh_checker #(
  parameter int DAC_W = 10
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             resetn,
  // bus handshake
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  // loop side
  input wire logic             cmpValid,
  input wire logic             refValid,
  input wire logic [DAC_W-1:0] tuneCode,
  input wire logic             lockFlag,
  input wire logic             holdover,
  input wire logic             dacHold,
  input wire logic [DAC_W-1:0] dacCode
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_lockRise; $rose(lockFlag) |-> $past(cmpValid) && !$past(holdover); endproperty
  a_lockRise: assert property (p_lockRise) else $error("lock rose without comparison");
  property p_lockFall; $fell(lockFlag) |-> $past(cmpValid); endproperty
  a_lockFall: assert property (p_lockFall) else $error("lock fell without comparison");
  property p_holdIn; $rose(holdover) |-> $fell(lockFlag); endproperty
  a_holdIn: assert property (p_holdIn) else $error("holdover entered without lock loss");
  property p_holdPair; dacHold == holdover; endproperty
  a_holdPair: assert property (p_holdPair) else $error("hold drive differs from holdover");
  property p_holdOut; refValid [*4] ##0 holdover |=> !holdover; endproperty
  a_holdOut: assert property (p_holdOut) else $error("holdover kept with valid reference");
  property p_holdStable; holdover && $past(holdover) |-> $stable(dacCode); endproperty
  a_holdStable: assert property (p_holdStable) else $error("code moved in holdover");
  property p_track;
    !holdover && !$past(holdover) && $past(resetn, 2) |-> dacCode == $past(tuneCode);
  endproperty
  a_track: assert property (p_track) else $error("code does not follow tuning input");
  property p_ack; $fell(avs_waitrequest) |-> $past(avs_read || avs_write) ##1 avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bad bus acknowledge");
  c_lock: cover property ($rose(lockFlag));
  c_holdIn: cover property ($rose(holdover));
  c_holdOut: cover property ($fell(holdover));
endmodule
bind plh_lock_holdover plh_checker #(.DAC_W(DAC_W)) plh_checker_inst (
  .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cmpValid(cmpValid), .refValid(refValid),
  .tuneCode(tuneCode), .lockFlag(lockFlag), .holdover(holdover), .dacHold(dacHold),
  .dacCode(dacCode));
`default_nettype wire

// ===== tb/plh_lock_holdover_test.sv
// testbench: register, lock, holdover and output-source scenarios
`timescale 1ns/1ns
`default_nettype none
module plh_lock_holdover_test;
  import plh_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, irq, cmpValid, refValid, lockFlag, holdover, dacHold;
  logic        oscSelPair67, oscSelPair89;
  logic        inWindow = 1'b0;
  logic        refGood = 1'b0;
  logic [11:0] phaseErr;
  logic [9:0]  tuneCode, dacCode;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          n;
  always #4 clk = ~clk;
  plh_lock_holdover plh_lock_holdover_inst (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cmpValid(cmpValid), .phaseErr(phaseErr),
    .tuneCode(tuneCode), .refValid(refValid), .lockFlag(lockFlag), .holdover(holdover),
    .dacHold(dacHold), .dacCode(dacCode), .oscSelPair67(oscSelPair67),
    .oscSelPair89(oscSelPair89));
  plh_ref_model plh_ref_model_inst (.clk(clk), .inWindow(inWindow), .refGood(refGood),
    .cmpValid(cmpValid), .phaseErr(phaseErr), .tuneCode(tuneCode), .refValid(refValid));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // held until waitrequest is seen low; no timeout here, the watchdog ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmps(input int k);
    repeat (k) begin
      @(posedge clk);
      while (cmpValid !== 1'b1) @(posedge clk);
    end
  endtask
  // partial run, one miss, then a full run counted up to the lock
  task automatic lockDrop(input logic [31:0] ctrl, input logic expHold);
    bus(1'b1, ADDR_CTRL, ctrl);
    inWindow <= 1'b0;
    cmps(1);
    inWindow <= 1'b1;
    cmps(3);
    inWindow <= 1'b0;
    cmps(1);
    inWindow <= 1'b1;
    n = 0;
    do begin
      cmps(1);
      n++;
      @(posedge clk);
    end while (lockFlag !== 1'b1 && n < 20);
    chk(n, 32'h5);
    inWindow <= 1'b0;
    cmps(1);
    @(posedge clk);
    chk(lockFlag, 32'h0);
    chk(holdover, expHold);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [4:0]  a [6] = '{ADDR_CTRL, ADDR_LOCK_CNT, ADDR_WINDOW, ADDR_MANUAL_DAC_CODE, ADDR_IRQ_MASK, 5'h1c};
    logic [31:0] e [6] = '{32'h2, 32'h2710, 32'h10, 32'h200, 32'h0, 32'h0};
    foreach (a[i]) rdchk(a[i], e[i]);
    bus(1'b1, 5'h1c, 32'hffff);
    rdchk(5'h1c, 32'h0);
    bus(1'b1, ADDR_LOCK_CNT, 32'h5);
    rdchk(ADDR_LOCK_CNT, 32'h5);
  endtask
  task automatic t_lock();
    lockDrop(32'h00, 1'b0);
    lockDrop(32'h12, 1'b0);
  endtask
  task automatic t_hold();
    logic [9:0] t;
    bus(1'b1, ADDR_MANUAL_DAC_CODE, 32'h200);
    bus(1'b1, ADDR_IRQ_MASK, 32'h6);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    lockDrop(32'h0a, 1'b1);
    chk(dacCode, 32'h200);
    @(posedge clk);
    chk(irq, 32'h1);
    rdchk(ADDR_IRQ_STAT, 32'h7);
    @(posedge clk);
    chk(irq, 32'h0);
    rdchk(ADDR_STATUS, 32'h2002);
    repeat (8) @(posedge clk);
    chk(dacCode, 32'h200);
    refGood <= 1'b1;
    n = 0;
    while (holdover !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(holdover, 32'h0);
    t = tuneCode;
    @(posedge clk);
    chk(dacCode, t);
    rdchk(ADDR_IRQ_STAT, 32'h8);
    refGood <= 1'b0;
  endtask
  task automatic t_osc();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, 32'h12 | (i << 5));
      @(posedge clk);
      chk({oscSelPair89, oscSelPair67}, i);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    chk(dacCode, 32'h200);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_lock();
    t_hold();
    t_osc();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
